// ===== verilog/pipf_pkg.sv
// Constants and carrier types for the pending-request flag block.
// Assumes a 32-bit APB master and a CPU that accepts one request at a time.
package pipf_pkg;

	localparam int NSRC = 14;
	localparam int NREG = 5;
	localparam int ADDR_W = 20;

	// Register indices; byte address is four times the index
	localparam logic [17:0] PEND_IDX [NREG] = '{
		18'h0f01b, 18'h0f01c, 18'h0f01d, 18'h0f01e, 18'h0f01f
	};
	localparam logic [17:0] ENAB_IDX [NREG] = '{
		18'h0f013, 18'h0f014, 18'h0f015, 18'h0f016, 18'h0f017
	};
	localparam logic [17:0] MIE_IDX = 18'h0f020;
	localparam int MIE_BIT = 0;

	localparam logic [7:0] PEND_RESET = 8'h00;
	localparam logic [7:0] ENAB_RESET = 8'h00;
	localparam logic MIE_RESET = 1'b0;

	// Register selector codes
	localparam logic [3:0] SEL_PEND0 = 4'h0;
	localparam logic [3:0] SEL_ENAB0 = 4'h5;
	localparam logic [3:0] SEL_MIE = 4'ha;
	localparam logic [3:0] SEL_NONE = 4'hf;

	// Source number is also its priority rank, 0 highest
	localparam int SRC_REG [NSRC] = '{0, 0, 0, 0, 1, 1, 2, 2, 3, 3, 3, 3, 4, 4};
	localparam int SRC_BIT [NSRC] = '{0, 1, 2, 3, 0, 1, 6, 7, 0, 1, 5, 7, 0, 3};

	typedef struct packed {
		logic timebase_2hz_event;
		logic timebase_16hz_event;
		logic timebase_32hz_event;
		logic timebase_128hz_event;
		logic pwm_five_event;
		logic pwm_four_event;
		logic timer_b_event;
		logic timer_a_event;
		logic uart_one_event;
		logic uart_zero_event;
		logic timer_nine_event;
		logic timer_eight_event;
		logic timer_one_event;
		logic timer_zero_event;
	} pipf_events_t;

	typedef struct packed {
		logic valid;
		logic [3:0] source;
	} pipf_request_t;

endpackage

// ===== verilog/pipf_irq_pending.sv
// Pending-request flags for fourteen peripheral sources, APB register access,
// and a prioritised request to the CPU core.
// Assumes events and CPU handshake signals are synchronous one-cycle pulses.
//
// Contract
// (R1) A peripheral event sets its pending flag regardless of enables.
// (R2) Request asserted only while flag, its enable and master enable are 1.
// (R3) Software writing 1 to an implemented flag sets it.
// (R4) CPU acceptance clears only the accepted source's flag.
// (R5) Interrupt from a flag or enable write waits one further instruction.
// (R6) First register bits 0..3 are timers 0, 1, 8, 9.
// (R7) Second register bits 0, 1 are UART 0, 1; others read 0.
// (R8) Third register bits 6, 7 are timers A, B.
// (R9) Fourth register: PWM4 bit 0, PWM5 bit 1, 128 Hz bit 5, 32 Hz bit 7.
// (R10) Flag registers are 8 bits, reset zero; 1 means pending.
// (R11) Fifth register: 16 Hz bit 0, 2 Hz bit 3.
// (R12) Highest-priority enabled pending source is presented first.
// (R13) Acceptance clears master enable, keeps individual enables.
// (R14) Writing 0 clears a flag unless its event arrives that cycle.
// (R15) Unassigned bits ignore writes and read as zero.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps

module pipf_irq_pending (
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pipf_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire pipf_pkg::pipf_events_t events,
	input wire logic irq_ack,
	input wire logic instr_retired,
	output pipf_pkg::pipf_request_t request
);

	logic [pipf_pkg::NSRC-1:0] pend_reg;
	logic [pipf_pkg::NSRC-1:0] enab_reg;
	logic mie_reg;
	logic hold_reg;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	pipf_pkg::pipf_request_t request_reg;
	pipf_pkg::pipf_request_t request_next;

	logic [pipf_pkg::NSRC-1:0] event_vec;
	logic [3:0] setup_sel;
	logic [3:0] access_sel;
	logic wr_en;
	logic ack_now;
	logic [pipf_pkg::NSRC-1:0] active;

	// Maps a byte address to a register selector
	function automatic logic [3:0] reg_sel(input logic [pipf_pkg::ADDR_W-1:0] a);
		logic [3:0] s;
		logic [17:0] idx;
		s = pipf_pkg::SEL_NONE;
		idx = a[19:2];
		if (a[1:0] == 2'h0) begin
			for (int r = 0; r < pipf_pkg::NREG; r++) begin
				if (idx == pipf_pkg::PEND_IDX[r]) begin
					s = pipf_pkg::SEL_PEND0 + 4'(r);
				end
				if (idx == pipf_pkg::ENAB_IDX[r]) begin
					s = pipf_pkg::SEL_ENAB0 + 4'(r);
				end
			end
			if (idx == pipf_pkg::MIE_IDX) begin
				s = pipf_pkg::SEL_MIE;
			end
		end
		return s;
	endfunction

	// Packs the bits of one register from a per-source vector
	function automatic logic [7:0] pack_byte(
		input logic [pipf_pkg::NSRC-1:0] v,
		input int r
	);
		logic [7:0] b;
		b = 8'h00;
		for (int s = 0; s < pipf_pkg::NSRC; s++) begin
			if (pipf_pkg::SRC_REG[s] == r) begin
				b[pipf_pkg::SRC_BIT[s]] = v[s];
			end
		end
		return b;
	endfunction

	assign event_vec = events;
	assign setup_sel = reg_sel(paddr);
	assign access_sel = setup_sel;
	assign wr_en = psel && penable && pready_reg && pwrite && pstrb[0];
	assign ack_now = irq_ack && request_reg.valid;

	// Pending flags, one slice per source
	generate
		for (genvar g = 0; g < pipf_pkg::NSRC; g++) begin : g_pend
			localparam logic [3:0] MY_SEL = pipf_pkg::SEL_PEND0 + 4'(pipf_pkg::SRC_REG[g]);
			localparam int MY_BIT = pipf_pkg::SRC_BIT[g];
			logic wr_hit;
			assign wr_hit = wr_en && (access_sel == MY_SEL);

			always_ff @(posedge clk) begin
				if (!rstn) begin
					pend_reg[g] <= pipf_pkg::PEND_RESET[MY_BIT]; // [R10]
				end else if (event_vec[g]) begin
					pend_reg[g] <= 1'b1; // [R1] [R14]
				end else if (wr_hit) begin
					pend_reg[g] <= pwdata[MY_BIT]; // [R3] [R14]
				end else if (ack_now && request_reg.source == 4'(g)) begin
					pend_reg[g] <= 1'b0; // [R4]
				end
			end
		end
	endgenerate

	// Individual enables, untouched by acceptance
	generate
		for (genvar g = 0; g < pipf_pkg::NSRC; g++) begin : g_enab
			localparam logic [3:0] MY_SEL = pipf_pkg::SEL_ENAB0 + 4'(pipf_pkg::SRC_REG[g]);
			localparam int MY_BIT = pipf_pkg::SRC_BIT[g];

			always_ff @(posedge clk) begin
				if (!rstn) begin
					enab_reg[g] <= pipf_pkg::ENAB_RESET[MY_BIT];
				end else if (wr_en && access_sel == MY_SEL) begin
					enab_reg[g] <= pwdata[MY_BIT]; // [R13]
				end
			end
		end
	endgenerate

	// Master enable; acceptance beats a same-cycle write
	always_ff @(posedge clk) begin
		if (!rstn) begin
			mie_reg <= pipf_pkg::MIE_RESET;
		end else if (ack_now) begin
			mie_reg <= 1'b0; // [R13]
		end else if (wr_en && access_sel == pipf_pkg::SEL_MIE) begin
			mie_reg <= pwdata[pipf_pkg::MIE_BIT];
		end
	end

	// Holds off requests after a flag or enable write until one instruction retires
	always_ff @(posedge clk) begin
		if (!rstn) begin
			hold_reg <= 1'b0;
		end else if (wr_en && access_sel < pipf_pkg::SEL_MIE) begin
			hold_reg <= 1'b1; // [R5]
		end else if (instr_retired) begin
			hold_reg <= 1'b0; // [R5]
		end
	end

	// Enabled and pending sources
	assign active = pend_reg & enab_reg; // [R2]

	// Lowest source number wins
	always_comb begin
		request_next.valid = 1'b0;
		request_next.source = 4'h0;
		for (int s = pipf_pkg::NSRC - 1; s >= 0; s--) begin
			if (active[s]) begin
				request_next.source = 4'(s); // [R12]
			end
		end
		request_next.valid = mie_reg && (|active) && !hold_reg && !ack_now; // [R2] [R5]
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			request_reg <= '0;
		end else begin
			request_reg <= request_next;
		end
	end

	// APB answer: ready in the first access cycle, data fetched at setup
	always_ff @(posedge clk) begin
		if (!rstn) begin
			pready_reg <= 1'b0;
		end else begin
			pready_reg <= psel && !penable;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			pslverr_reg <= 1'b0;
		end else begin
			pslverr_reg <= psel && !penable && setup_sel == pipf_pkg::SEL_NONE;
		end
	end

	// Read mux; unassigned bits come back zero
	always_ff @(posedge clk) begin
		if (!rstn) begin
			prdata_reg <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata_reg <= 32'h0000_0000;
			for (int r = 0; r < pipf_pkg::NREG; r++) begin
				if (setup_sel == pipf_pkg::SEL_PEND0 + 4'(r)) begin
					prdata_reg[7:0] <= pack_byte(pend_reg, r); // [R6] [R7] [R8] [R9] [R11] [R15]
				end
				if (setup_sel == pipf_pkg::SEL_ENAB0 + 4'(r)) begin
					prdata_reg[7:0] <= pack_byte(enab_reg, r); // [R15]
				end
			end
			if (setup_sel == pipf_pkg::SEL_MIE) begin
				prdata_reg[pipf_pkg::MIE_BIT] <= mie_reg;
			end
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign request = request_reg;

endmodule

// ===== bench/pipf_irq_pending_props.sv
// Checker for the pending-flag block.
// Assumes it sees the block's ports through the bind below.
`timescale 1ns/1ps
module pipf_props (
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pipf_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic irq_ack,
	input wire logic instr_retired,
	input wire pipf_pkg::pipf_request_t request
);
	logic wr;
	logic mie_q;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	assign wr = psel && penable && pready && pwrite && pstrb[0] && paddr[1:0] == 2'b00;
	always_ff @(posedge clk) begin
		if (!rstn)
			mie_q <= 1'b0;
		else if (irq_ack && request.valid)
			mie_q <= 1'b0;
		else if (wr && paddr[19:2] == pipf_pkg::MIE_IDX)
			mie_q <= pwdata[0];
	end
	rdy_setup_a: assert property (psel && !penable |=> pready) else $error("no answer");
	rdy_once_a: assert property (pready |=> !pready) else $error("ready held");
	bad_addr_a: assert property (psel && !penable && paddr[1:0] != 2'b00 |=> pslverr)
		else $error("misaligned accepted");
	err_rdy_a: assert property (pslverr |-> pready) else $error("lone error");
	high_zero_a: assert property (pready |-> prdata[31:8] == 24'h0) else $error("high bits");
	ack_drop_a: assert property (irq_ack && request.valid |=> !request.valid)
		else $error("request after accept");
	mie_gate_a: assert property (request.valid |-> $past(mie_q)) else $error("request masked");
	wr_hold_a: assert property (wr && paddr[19:2] inside {[18'h0f013:18'h0f017],
		[18'h0f01b:18'h0f01f]} ##1 !instr_retired |=> !request.valid) else $error("no hold");
	ack_c: cover property (irq_ack && request.valid);
	err_c: cover property (pslverr);
	mie_c: cover property (wr && paddr[19:2] == pipf_pkg::MIE_IDX);
endmodule
bind pipf_irq_pending pipf_props props (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pstrb, .prdata, .pready, .pslverr, .irq_ack, .instr_retired, .request);

// ===== bench/pipf_cpu.sv
// CPU model: retires one instruction in four cycles, accepts after lat.
// Assumes a registered request from the block.
`timescale 1ns/1ps
module pipf_cpu (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [3:0] lat,
	input wire pipf_pkg::pipf_request_t request,
	output logic irq_ack,
	output logic instr_retired
);
	logic [3:0] wait_cnt;
	logic [1:0] ph;
	assign irq_ack = request.valid && wait_cnt >= lat;
	assign instr_retired = ph == 2'h3;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			wait_cnt <= 4'h0;
			ph <= 2'h0;
		end else begin
			ph <= ph + 2'h1;
			wait_cnt <= request.valid && !irq_ack ? wait_cnt + 4'h1 : 4'h0;
		end
	end
endmodule

// ===== bench/tb_peripheral_irq_pending_flags.sv
// Bench: APB master, event pulses and the CPU model.
// Assumes the package's register indices.
`timescale 1ns/1ps
module tb_peripheral_irq_pending_flags;
	logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq_ack, ir, e;
	logic [19:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, seed = 32'h8c5aa8a4;
	logic [3:0] pstrb = 4'hf, lat = '0;
	logic [1:0] lo = '0;
	logic [7:0] r;
	logic [13:0] pend;
	pipf_pkg::pipf_events_t events = '0;
	pipf_pkg::pipf_request_t request;
	int num_errors = 0, n_checks = 0, k, s;
	int rb[14] = '{0, 1, 2, 3, 8, 9, 22, 23, 24, 25, 29, 31, 32, 35};
	logic [7:0] msk[5] = '{8'h0f, 8'h03, 8'hc0, 8'ha3, 8'h09};
	always #12.5 clk = ~clk;
	pipf_irq_pending DUT (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .events, .irq_ack, .instr_retired(ir), .request);
	pipf_cpu cpu (.clk, .rstn, .lat, .request, .irq_ack, .instr_retired(ir));
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] t;
		t = v;
		t ^= t << 13;
		t ^= t >> 17;
		t ^= t << 5;
		return t;
	endfunction
	function automatic logic [7:0] regval(input logic [13:0] p, input int g);
		regval = 8'h00;
		for (int i = 0; i < 14; i++)
			if (p[i] && rb[i] / 8 == g) regval[rb[i] % 8] = 1'b1;
	endfunction
	task automatic check(input string n, input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s exp %h got %h", n, exp, got);
		end
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [17:0] ix, input logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {ix, lo};
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		for (k = 0; k < 9; k++) begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		if (k == 9) begin
			num_errors++;
			conclude();
		end
		r = prdata[7:0];
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic pulse(input logic [13:0] v);
		@(posedge clk);
		events <= v;
		@(posedge clk);
		events <= '0;
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		for (int g = 0; g < 5; g++) begin
			apb(0, pipf_pkg::PEND_IDX[g], 0);
			check("reset", r, 8'h00);
			apb(1, pipf_pkg::PEND_IDX[g], 8'hff);
			apb(0, pipf_pkg::PEND_IDX[g], 0);
			check("set", r, msk[g]);
			apb(1, pipf_pkg::PEND_IDX[g], 8'h00);
			apb(0, pipf_pkg::PEND_IDX[g], 0);
			check("clear", r, 8'h00);
		end
		lo = 2'b01;
		apb(0, pipf_pkg::PEND_IDX[0], 0);
		lo = 2'b00;
		check("refused", {e, r[6:0]}, 8'h80);
		for (int i = 0; i < 14; i++) begin
			pulse(14'(1 << i));
			apb(0, pipf_pkg::PEND_IDX[rb[i] / 8], 0);
			check("event", r, 8'(1 << rb[i] % 8));
			apb(1, pipf_pkg::PEND_IDX[rb[i] / 8], 0);
		end
		for (int g = 0; g < 5; g++)
			apb(1, pipf_pkg::ENAB_IDX[g], 8'hff);
		repeat (6) begin
			pend = 14'(seed);
			seed = xs(seed);
			lat <= 4'(seed % 8);
			pulse(pend);
			while (pend != 0) begin
				apb(1, pipf_pkg::MIE_IDX, 8'h01);
				for (k = 0; k < 40 && !(irq_ack === 1'b1 && request.valid === 1'b1); k++)
					@(negedge clk);
				if (k == 40) begin
					num_errors++;
					conclude();
				end
				s = 0;
				while (!pend[s])
					s++;
				check("source", 8'(request.source), 8'(s));
				pend[s] = 1'b0;
				apb(0, pipf_pkg::PEND_IDX[rb[s] / 8], 0);
				check("accepted", r, regval(pend, rb[s] / 8));
			end
		end
		for (int g = 0; g < 5; g++) begin
			apb(0, pipf_pkg::ENAB_IDX[g], 0);
			check("enables kept", r, msk[g]);
		end
		conclude();
	end
endmodule
